/* File: bench/pcg_clock_gate_chk.sv */
// Checker for bus answers and fault timing of the gate bank
`timescale 1ns/1ps
module pcg_clock_gate_chk
(
  input logic       sys_clk,       // Clock
  input logic       nrst,          // Reset, low
  input logic       s_axi_arvalid, // Read request
  input logic       s_axi_arready, // Read accept
  input logic       s_axi_rvalid,  // Read answer
  input logic       s_axi_rready,  // Read taken
  input logic       s_axi_bvalid,  // Write answer
  input logic       s_axi_bready,  // Write taken
  input logic [3:0] unitAccess,    // Unit strobes
  input logic [3:0] unitFault,     // Fault pulses
  input logic       watchdogClkEn, // Watchdog on
  input logic       canClkEn       // CAN on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid) else $error("read answer dropped");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read answer stuck");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write answer dropped");
  wdog_fault_a: assert property (unitAccess[0] && !watchdogClkEn
    |=> unitFault[0]) else $error("watchdog fault missing");
  can_fault_a: assert property (unitAccess[3] && !canClkEn
    |=> unitFault[3]) else $error("can fault missing");
  wdog_quiet_a: assert property (unitAccess[0] && watchdogClkEn
    |=> !unitFault[0]) else $error("fault on clocked unit");
  fault_cause_a: assert property ((unitFault & ~$past(unitAccess))
    == 4'h0) else $error("fault without access");
  cover property (unitFault[0]);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind pcg_clock_gate pcg_clock_gate_chk chk (.sys_clk, .nrst, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
  .unitAccess, .unitFault, .watchdogClkEn, .canClkEn);

/* File: bench/pcg_clock_gate_tb.sv */
// Bench for the gate bank: registers, enables, faults, irq
`timescale 1ns/1ps
module pcg_clock_gate_tb;
  logic        sys_clk = 1'h0;
  logic        nrst = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, poke = 4'h0, unitAccess, unitFault;
  logic [1:0]  powerMode = 2'h0, s_axi_bresp, s_axi_rresp, adcSampleSpeed;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, watchdogClkEn, pwmClkEn, canClkEn, adcClkEn, irq;
  int          error_cnt = 0, checks = 0;
  int          bitPos [4] = '{3, 16, 20, 24};
  always #10 sys_clk = ~sys_clk;
  pcg_clock_gate uut (.*);
  pcg_unit_stub stub (.sys_clk, .poke, .unitAccess);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      checks++;
      if (g !== e)
      begin
        error_cnt++;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Ready is raised only after the answer shows, so the hold path is used
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] r);
    logic ta, tw, tv, dn;
    logic [31:0] dv;
    logic [1:0] rs;
    begin
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_arvalid <= !w;
      dn = 1'h0;
      while (!dn)
      begin
        @(negedge sys_clk);
        ta = w ? s_axi_awready : s_axi_arready;
        tw = s_axi_wready;
        tv = w ? s_axi_bvalid : s_axi_rvalid;
        dn = tv && (w ? s_axi_bready : s_axi_rready);
        dv = s_axi_rdata;
        rs = w ? s_axi_bresp : s_axi_rresp;
        @(posedge sys_clk);
        if (ta)
          {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
        if (tw)
          s_axi_wvalid <= 1'h0;
        s_axi_bready <= w && tv && !dn;
        s_axi_rready <= !w && tv && !dn;
      end
      if (!w)
        chk("rdata", d, dv);
      chk("resp", {30'h0, r}, {30'h0, rs});
    end
  endtask
  task see(input string nm, input logic [3:0] e);
    begin
      @(negedge sys_clk);
      if (nm == "irq")
        chk(nm, {28'h0, e}, {31'h0, irq});
      else
        chk(nm, {28'h0, e}, {28'h0, canClkEn, pwmClkEn, adcClkEn,
          watchdogClkEn});
      @(posedge sys_clk);
    end
  endtask
  task hit(input logic [3:0] m, input logic [3:0] e);
    begin
      poke <= m;
      @(posedge sys_clk);
      poke <= 4'h0;
      repeat (2) @(negedge sys_clk);
      chk("unitFault", {28'h0, e}, {28'h0, unitFault});
      @(posedge sys_clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'h1;
    xfer(1'h0, 12'h100, 32'h40, 2'h0);
    xfer(1'h0, 12'h110, 32'h40, 2'h0);
    xfer(1'h0, 12'h120, 32'h40, 2'h0);
    see("en", 4'h0);
    hit(4'hF, 4'hF);
    for (int b = 0; b < 4; b++)
    begin
      xfer(1'h1, 12'h100, 32'h1 << bitPos[b], 2'h0);
      see("en", 4'h1 << b);
    end
    hit(4'hF, 4'h7);
    xfer(1'h1, 12'h100, 32'hFFFFFEFF, 2'h0);
    xfer(1'h0, 12'h100, 32'h01110248, 2'h0);
    hit(4'hF, 4'h0);
    xfer(1'h1, 12'h120, 32'hFFFFFFFF, 2'h0);
    xfer(1'h0, 12'h120, 32'h01110048, 2'h0);
    for (int s = 0; s < 3; s++)
    begin
      xfer(1'h1, 12'h100, 32'h8 | (s << 8), 2'h0);
      @(negedge sys_clk);
      chk("speed", s, {30'h0, adcSampleSpeed});
      @(posedge sys_clk);
    end
    xfer(1'h1, 12'h110, 32'h00100040, 2'h0);
    powerMode <= 2'h1;
    repeat (4) @(posedge sys_clk);
    see("en", 4'h1);
    xfer(1'h1, 12'h130, 32'h1, 2'h0);
    see("en", 4'h4);
    powerMode <= 2'h2;
    repeat (4) @(posedge sys_clk);
    see("en", 4'hF);
    powerMode <= 2'h0;
    repeat (4) @(posedge sys_clk);
    xfer(1'h1, 12'h134, 32'h3, 2'h0);
    hit(4'h2, 4'h2);
    see("irq", 4'h0);
    xfer(1'h1, 12'h138, 32'h1, 2'h0);
    see("irq", 4'h1);
    xfer(1'h1, 12'h134, 32'h1, 2'h0);
    see("irq", 4'h0);
    xfer(1'h1, 12'h140, 32'h1, 2'h2);
    xfer(1'h0, 12'h140, 32'h0, 2'h2);
    tally_and_finish;
  end
  // Whole run is about 130 cycles; this cuts a hang
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish;
  end
endmodule

/* File: bench/pcg_unit_stub.sv */
// Gated units stand-in: a poke becomes one access strobe
`timescale 1ns/1ps
module pcg_unit_stub
(
  input  logic       sys_clk,   // Clock
  input  logic [3:0] poke,      // Units to touch
  output logic [3:0] unitAccess // Access strobe
);
  always @(posedge sys_clk)
    unitAccess <= poke;
endmodule

/* File: design/pcg_clock_gate.v */
// Peripheral clock gate bank 0 with AXI4-Lite registers and fault screen
//
// Behaviour
// - set gating bit clocks unit, clear stops it
// - access to unclocked unit returns bus fault
// - reset clears gates, register reads 0x00000040
// - bits 9:8 select converter sample rate
// - run, sleep, deep-sleep registers at 0x100/110/120
// - sleep registers apply only with auto gating
// - bit 3 gates the watchdog
// - bit 20 gates the PWM module
// - bit 24 gates CAN unit zero
`timescale 1ns/1ps
`include "pcg_consts.vh"

module pcg_clock_gate
(
  input  wire        sys_clk,        // System clock, 50 MHz
  input  wire        nrst,           // Asynchronous reset, active low
  input  wire [11:0] s_axi_awaddr,   // Write address
  input  wire        s_axi_awvalid,  // Write address valid
  output wire        s_axi_awready,  // Write address ready
  input  wire [31:0] s_axi_wdata,    // Write data
  input  wire [3:0]  s_axi_wstrb,    // Write byte strobes
  input  wire        s_axi_wvalid,   // Write data valid
  output wire        s_axi_wready,   // Write data ready
  output reg  [1:0]  s_axi_bresp,    // Write response
  output reg         s_axi_bvalid,   // Write response valid
  input  wire        s_axi_bready,   // Write response ready
  input  wire [11:0] s_axi_araddr,   // Read address
  input  wire        s_axi_arvalid,  // Read address valid
  output wire        s_axi_arready,  // Read address ready
  output reg  [31:0] s_axi_rdata,    // Read data
  output reg  [1:0]  s_axi_rresp,    // Read response
  output reg         s_axi_rvalid,   // Read data valid
  input  wire        s_axi_rready,   // Read data ready
  input  wire [1:0]  powerMode,      // Processor power state, async
  input  wire [3:0]  unitAccess,     // Access strobes: can,pwm,adc,wdog
  output reg  [3:0]  unitFault,      // Bus fault pulse per unit
  output reg         watchdogClkEn,  // Watchdog clock enable
  output reg         pwmClkEn,       // PWM clock enable
  output reg         canClkEn,       // CAN unit zero clock enable
  output reg         adcClkEn,       // Converter clock enable
  output reg  [1:0]  adcSampleSpeed, // Converter sample speed code
  output wire        irq             // Level interrupt
);

  reg  [31:0] runGate_r;
  reg  [31:0] sleepGate_r;
  reg  [31:0] deepGate_r;
  reg         autoGate_r;
  reg  [1:0]  irqStat_r;
  reg  [1:0]  irqMask_r;
  reg  [1:0]  modeMeta_r;
  reg  [1:0]  modeSync_r;
  reg  [11:0] awAddr_r;
  reg         awHeld_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;
  reg         wHeld_r;
  reg  [31:0] activeGate;
  reg  [31:0] rdVal;
  reg         rdHit;
  reg  [3:0]  enNxt;
  reg  [3:0]  enNow;
  reg  [1:0]  spdNxt;
  reg         sleepSel;
  reg         deepSel;
  reg  [1:0]  irqSet;
  reg  [1:0]  irqClr;
  reg  [1:0]  irqStat_nxt;
  wire        wrGo;

  // Byte-lane merge of write data into a register
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    input [31:0] wmask;
    integer i;
    begin
      laneMerge = old;
      for (i = 0; i < 32; i = i + 1)
        if (strb[i / 8] && wmask[i])
          laneMerge[i] = data[i];
    end
  endfunction

  // Pull the four unit enables out of a gating word
  function [3:0] unitBits;
    input [31:0] g;
    begin
      unitBits[3] = g[`PCG_BIT_CAN];
      unitBits[2] = g[`PCG_BIT_PWM];
      unitBits[1] = g[`PCG_BIT_ADC];
      unitBits[0] = g[`PCG_BIT_WATCHDOG];
    end
  endfunction

  // Power mode comes from another domain: two flops before use
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      modeMeta_r <= `PCG_MODE_RUN;
      modeSync_r <= `PCG_MODE_RUN;
    end
    else
    begin
      modeMeta_r <= powerMode;
      modeSync_r <= modeMeta_r;
    end
  end

  // Sleep registers only steer the gates when auto gating is on
  always @*
  begin
    // Mode code 3 is unused and falls back to the run register
    sleepSel   = autoGate_r && (modeSync_r == `PCG_MODE_SLEEP);
    deepSel    = autoGate_r && (modeSync_r == `PCG_MODE_DEEP);
    activeGate = runGate_r;
    if (sleepSel)
      activeGate = sleepGate_r;
    else if (deepSel)
      activeGate = deepGate_r;
    enNxt = unitBits(activeGate);
    enNow = {canClkEn, pwmClkEn, adcClkEn, watchdogClkEn};
    // Deep sleep has no speed field, so the run speed stays in force
    if (deepSel)
      spdNxt = runGate_r[`PCG_SPD_HI:`PCG_SPD_LO];
    else
      spdNxt = activeGate[`PCG_SPD_HI:`PCG_SPD_LO];
  end

  // Events of this cycle and the software clear of the status word
  always @*
  begin
    irqSet = {enNxt != enNow, |(unitAccess & ~enNow)};
    irqClr = 2'h0;
    if (wrGo && awAddr_r == `PCG_OFF_IRQ_STAT && wStrb_r[0])
      irqClr = wData_r[1:0];
    // A new event outranks a write-one clear in the same cycle
    irqStat_nxt = (irqStat_r & ~irqClr) | irqSet;
  end

  // Write channel: hold address and data until both are in
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
  assign wrGo          = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq           = |(irqStat_r & irqMask_r);

  always @*
  begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      `PCG_OFF_RUN:      rdVal = runGate_r;
      `PCG_OFF_SLEEP:    rdVal = sleepGate_r;
      `PCG_OFF_DEEP:     rdVal = deepGate_r;
      `PCG_OFF_CTRL:     rdVal = {31'h00000000, autoGate_r};
      `PCG_OFF_IRQ_STAT: rdVal = {30'h00000000, irqStat_r};
      `PCG_OFF_IRQ_MASK: rdVal = {30'h00000000, irqMask_r};
      default:
      begin
        rdVal = 32'h00000000;
        rdHit = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      runGate_r      <= `PCG_RESET_GATE;
      sleepGate_r    <= `PCG_RESET_GATE;
      deepGate_r     <= `PCG_RESET_GATE;
      autoGate_r     <= 1'b0;
      irqMask_r      <= 2'h0;
      awAddr_r       <= 12'h000;
      awHeld_r       <= 1'b0;
      wData_r        <= 32'h00000000;
      wStrb_r        <= 4'h0;
      wHeld_r        <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `PCG_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
      end

      if (wrGo)
      begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PCG_RESP_OKAY;
        case (awAddr_r)
          // Only documented fields take writes; bit 6 stays at one
          `PCG_OFF_RUN:
            runGate_r <= laneMerge(runGate_r, wData_r, wStrb_r,
                                   `PCG_WMASK_RS);
          `PCG_OFF_SLEEP:
            sleepGate_r <= laneMerge(sleepGate_r, wData_r, wStrb_r,
                                     `PCG_WMASK_RS);
          `PCG_OFF_DEEP:
            deepGate_r <= laneMerge(deepGate_r, wData_r, wStrb_r,
                                    `PCG_WMASK_DEEP);
          `PCG_OFF_CTRL:
            if (wStrb_r[0])
              autoGate_r <= wData_r[`PCG_CTRL_AUTO];
          `PCG_OFF_IRQ_STAT:
            ;
          `PCG_OFF_IRQ_MASK:
            if (wStrb_r[0])
              irqMask_r <= wData_r[1:0];
          default:
            s_axi_bresp <= `PCG_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: the answer stands until the master takes it
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `PCG_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdVal;
      s_axi_rresp  <= rdHit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Enables are registered so the gated clocks see clean levels;
  // the cost is one cycle of lag after a register or mode change
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      watchdogClkEn  <= 1'b0;
      pwmClkEn       <= 1'b0;
      canClkEn       <= 1'b0;
      adcClkEn       <= 1'b0;
      adcSampleSpeed <= `PCG_SPD_125K;
      unitFault      <= 4'h0;
    end
    else
    begin
      {canClkEn, pwmClkEn, adcClkEn, watchdogClkEn} <= enNxt;
      adcSampleSpeed <= spdNxt;
      // Unit accesses while the clock is off are faulted
      unitFault <= unitAccess & ~enNow;
    end
  end

  // Sticky interrupt status
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      irqStat_r <= 2'h0;
    else
      irqStat_r <= irqStat_nxt;
  end

endmodule

/* File: design/pcg_consts.vh */
// Offsets, field positions, reset values and codes for the gating bank
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH
`define PCG_OFF_RUN        12'h100
`define PCG_OFF_SLEEP      12'h110
`define PCG_OFF_DEEP       12'h120
`define PCG_OFF_CTRL       12'h130
`define PCG_OFF_IRQ_STAT   12'h134
`define PCG_OFF_IRQ_MASK   12'h138
`define PCG_BIT_WATCHDOG   3
`define PCG_BIT_RSVD_ONE   6
`define PCG_SPD_LO         8
`define PCG_SPD_HI         9
`define PCG_BIT_ADC        16
`define PCG_BIT_PWM        20
`define PCG_BIT_CAN        24
`define PCG_RESET_GATE     32'h00000040
`define PCG_WMASK_RS       32'h01110308
`define PCG_WMASK_DEEP     32'h01110008
`define PCG_SPD_125K       2'h0
`define PCG_SPD_250K       2'h1
`define PCG_SPD_500K       2'h2
`define PCG_MODE_RUN       2'h0
`define PCG_MODE_SLEEP     2'h1
`define PCG_MODE_DEEP      2'h2
`define PCG_CTRL_AUTO      0
`define PCG_IRQ_FAULT      0
`define PCG_IRQ_CHANGE     1
`define PCG_RESP_OKAY      2'h0
`define PCG_RESP_SLVERR    2'h2
`endif
